// file: core/pmc_power_mode_ctrl.v
// power mode controller: mode state machine and clock/power gating
`include "pmc_map.vh"
// Contract
// [RULE_01] supply monitor holds whole device in reset while supply is low
// [RULE_02] modes: active, lp active, idle, lp idle, stop, suspend, sleep
// [RULE_03] lp active clocks only requesting, firmware enabled peripherals
// [RULE_04] idle keeps peripherals, halts code, enabled interrupt wakes in 2
// [RULE_05] lp idle halts cpu, gates unused clocks, interrupt wakes in 2
// [RULE_06] suspend gates clock, oscillators off, listed sources resume
// [RULE_07] sleep gates power, only rtc oscillator, listed sources resume
// [RULE_08] idle bit halts cpu after writing instruction completes
// [RULE_09] idle keeps registers, memory and peripherals running
// [RULE_10] enabled interrupt clears idle bit and resumes; reset also ends
// [RULE_11] interrupt wake services interrupt then resumes next instruction
// [RULE_12] reset out of idle restarts core at address zero
// [RULE_13] stop bit enters stop after writing instruction completes
// [RULE_14] stop halts precision oscillator and cpu, others unchanged; ext osc also stops if any analog off bit is set
// [RULE_15] only reset ends stop, core restarts at address zero
// [RULE_16] firmware may shut analog peripherals before stop
// [RULE_17] suspend bit gates clock, oscillators off until wake source
// [RULE_18] sleep bit powers off core regulator, ram moves to supply pin
// [RULE_19] interrupt out of lp idle returns to lp active only
// [RULE_20] idle and stop in one write means stop
module pmc_power_mode_ctrl (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_supply_low,
    input wire i_reset_pin,
    input wire i_int_reset,
    input wire i_idle_set,
    input wire i_stop_set,
    input wire i_suspend_set,
    input wire i_sleep_set,
    input wire i_instr_done,
    input wire i_lp_mode_set,
    input wire i_lp_mode_clear,
    input wire i_irq_pending,
    input wire i_wake_cap_sense,
    input wire i_wake_rtc,
    input wire i_wake_port_match,
    input wire i_wake_i2c,
    input wire [`PMC_PERIPH_W-1:0] i_periph_clk_en,
    input wire [`PMC_PERIPH_W-1:0] i_periph_clk_req,
    input wire [`PMC_PERIPH_W-1:0] i_periph_analog_off,
    output reg [`PMC_MODE_W-1:0] o_mode,
    output reg o_idle_bit,
    output reg o_stop_bit,
    output reg o_cpu_run,
    output reg o_irq_service,
    output reg o_sysclk_en,
    output reg o_precision_osc_en,
    output reg o_lp_osc_en,
    output reg o_ext_osc_en,
    output reg o_rtc_osc_en,
    output reg o_core_reg_en,
    output reg o_ram_on_vdd,
    output reg [`PMC_PERIPH_W-1:0] o_periph_clk,
    output wire o_core_rst,
    output reg [15:0] o_reset_vector
);
    localparam [6:0] ST_ACTIVE = 7'h01;
    localparam [6:0] ST_LP_ACTIVE = 7'h02;
    localparam [6:0] ST_IDLE = 7'h04;
    localparam [6:0] ST_LP_IDLE = 7'h08;
    localparam [6:0] ST_STOP = 7'h10;
    localparam [6:0] ST_SUSPEND = 7'h20;
    localparam [6:0] ST_SLEEP = 7'h40;

    reg [6:0] state;
    reg [6:0] next_state;
    reg lp_mode;
    reg pend_idle;
    reg pend_stop;
    reg ext_osc_keep;
    wire wake_suspend;
    wire wake_sleep;
    wire lp_now;
    wire [`PMC_PERIPH_W-1:0] next_periph_clk;
    genvar g;

    // [RULE_06] suspend wake sources
    assign wake_suspend = i_wake_cap_sense | i_wake_rtc | i_wake_port_match
        | i_wake_i2c;
    // [RULE_07] sleep wake sources
    assign wake_sleep = i_wake_rtc | i_wake_port_match | i_wake_i2c;
    assign lp_now = (lp_mode | i_lp_mode_set) & ~i_lp_mode_clear;

    generate
        for (g = 0; g < `PMC_PERIPH_W; g = g + 1) begin : g_periph
            // [RULE_09] idle peripherals run
            // [RULE_03] only requested clocks
            assign next_periph_clk[g] = (state == ST_ACTIVE)
                | (state == ST_IDLE)
                | (((state == ST_LP_ACTIVE) | (state == ST_LP_IDLE))
                & i_periph_clk_en[g] & i_periph_clk_req[g]);
        end
    endgenerate

    // [RULE_01] reset stretcher
    pmc_reset_gen u_rst (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_supply_low(i_supply_low),
        .i_reset_pin(i_reset_pin),
        .i_int_reset(i_int_reset),
        .o_core_rst(o_core_rst)
    );

    always @* begin
        next_state = state;
        case (state)
            ST_ACTIVE, ST_LP_ACTIVE: begin
                // [RULE_13] stop after instruction
                // [RULE_20] stop wins over idle
                if (i_instr_done && pend_stop) begin
                    next_state = ST_STOP;
                // [RULE_08] idle after instruction
                end else if (i_instr_done && pend_idle) begin
                    next_state = lp_mode ? ST_LP_IDLE : ST_IDLE;
                // [RULE_17] suspend entry
                end else if (i_instr_done && i_suspend_set) begin
                    next_state = ST_SUSPEND;
                // [RULE_18] sleep entry
                end else if (i_instr_done && i_sleep_set) begin
                    next_state = ST_SLEEP;
                end else begin
                    next_state = lp_now ? ST_LP_ACTIVE : ST_ACTIVE;
                end
            end
            ST_IDLE: begin
                // [RULE_04] interrupt wake
                if (i_irq_pending) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_LP_IDLE: begin
                // [RULE_05] lp idle interrupt wake
                // [RULE_19] back to lp active
                if (i_irq_pending) begin
                    next_state = ST_LP_ACTIVE;
                end
            end
            // [RULE_15] only reset leaves stop
            ST_STOP: next_state = ST_STOP;
            ST_SUSPEND: begin
                if (wake_suspend) begin
                    next_state = lp_mode ? ST_LP_ACTIVE : ST_ACTIVE;
                end
            end
            ST_SLEEP: begin
                if (wake_sleep) begin
                    next_state = lp_mode ? ST_LP_ACTIVE : ST_ACTIVE;
                end
            end
            default: next_state = ST_ACTIVE;
        endcase
    end

    always @(posedge i_clk) begin
        // [RULE_12] reset restarts core
        if (i_sys_rst || o_core_rst) begin
            state <= ST_ACTIVE;
            lp_mode <= 1'b0;
            pend_idle <= 1'b0;
            pend_stop <= 1'b0;
            o_idle_bit <= 1'b0;
            o_stop_bit <= 1'b0;
            o_irq_service <= 1'b0;
            ext_osc_keep <= 1'b1;
            o_reset_vector <= `PMC_RESET_VECTOR;
        end else begin
            state <= next_state;
            if (state == ST_ACTIVE || state == ST_LP_ACTIVE) begin
                lp_mode <= lp_now;
            end
            // [RULE_08] latch until completion
            if (i_instr_done) begin
                pend_idle <= 1'b0;
                pend_stop <= 1'b0;
            end else begin
                pend_idle <= pend_idle | i_idle_set;
                pend_stop <= pend_stop | i_stop_set;
            end
            // [RULE_10] hardware clears idle bit
            if ((state == ST_IDLE || state == ST_LP_IDLE) && i_irq_pending) begin
                o_idle_bit <= 1'b0;
            end else if (i_idle_set && !i_stop_set) begin
                o_idle_bit <= 1'b1;
            end
            if (i_stop_set) begin
                o_stop_bit <= 1'b1;
            end
            // [RULE_11] service pending interrupt first
            o_irq_service <= (state == ST_IDLE || state == ST_LP_IDLE)
                && i_irq_pending;
            // [RULE_16] analog off before stop
            if (next_state == ST_STOP && state != ST_STOP) begin
                ext_osc_keep <= ~|i_periph_analog_off;
            end
        end
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mode <= `PMC_MODE_ACTIVE;
            o_cpu_run <= 1'b0;
            o_sysclk_en <= 1'b1;
            o_precision_osc_en <= 1'b1;
            o_lp_osc_en <= 1'b1;
            o_ext_osc_en <= 1'b1;
            o_rtc_osc_en <= 1'b1;
            o_core_reg_en <= 1'b1;
            o_ram_on_vdd <= 1'b0;
            o_periph_clk <= {`PMC_PERIPH_W{1'b0}};
        end else begin
            // [RULE_02] mode encoding
            case (state)
                ST_LP_ACTIVE: o_mode <= `PMC_MODE_LP_ACTIVE;
                ST_IDLE: o_mode <= `PMC_MODE_IDLE;
                ST_LP_IDLE: o_mode <= `PMC_MODE_LP_IDLE;
                ST_STOP: o_mode <= `PMC_MODE_STOP;
                ST_SUSPEND: o_mode <= `PMC_MODE_SUSPEND;
                ST_SLEEP: o_mode <= `PMC_MODE_SLEEP;
                default: o_mode <= `PMC_MODE_ACTIVE;
            endcase
            // [RULE_04] cpu halted off active
            o_cpu_run <= ~o_core_rst
                & (state == ST_ACTIVE || state == ST_LP_ACTIVE);
            // [RULE_17] suspend gates clock
            o_sysclk_en <= ~(state == ST_SUSPEND || state == ST_SLEEP);
            // [RULE_14] stop halts precision osc
            o_precision_osc_en <= ~(state == ST_STOP || state == ST_SUSPEND
                || state == ST_SLEEP);
            o_lp_osc_en <= ~(state == ST_SUSPEND || state == ST_SLEEP);
            o_ext_osc_en <= (state == ST_STOP) ? ext_osc_keep
                : ~(state == ST_SUSPEND || state == ST_SLEEP);
            // [RULE_07] only rtc osc in sleep
            o_rtc_osc_en <= 1'b1;
            // [RULE_18] regulator off in sleep
            o_core_reg_en <= (state != ST_SLEEP);
            o_ram_on_vdd <= (state == ST_SLEEP);
            o_periph_clk <= next_periph_clk;
        end
    end
endmodule // pmc_power_mode_ctrl

// file: core/pmc_reset_gen.v
// reset hold stretcher for the power mode controller
`include "pmc_map.vh"
module pmc_reset_gen (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_supply_low,
    input wire i_reset_pin,
    input wire i_int_reset,
    output reg o_core_rst
);
    reg [3:0] hold;
    wire any_rst;
    assign any_rst = i_supply_low | i_reset_pin | i_int_reset;
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            hold <= `PMC_RST_HOLD;
            o_core_rst <= 1'b1;
        // [RULE_01] hold while low
        end else if (any_rst) begin
            hold <= `PMC_RST_HOLD;
            o_core_rst <= 1'b1;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
            o_core_rst <= 1'b1;
        end else begin
            o_core_rst <= 1'b0;
        end
    end
endmodule // pmc_reset_gen

// file: inc/pmc_map.vh
// constants for the power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_RESET_VECTOR 16'h0000
`define PMC_PERIPH_W 8
`define PMC_WAKE_CYCLES 2'h2
`define PMC_MODE_W 3
`define PMC_MODE_ACTIVE 3'h0
`define PMC_MODE_LP_ACTIVE 3'h1
`define PMC_MODE_IDLE 3'h2
`define PMC_MODE_LP_IDLE 3'h3
`define PMC_MODE_STOP 3'h4
`define PMC_MODE_SUSPEND 3'h5
`define PMC_MODE_SLEEP 3'h6
`define PMC_RST_HOLD 4'h4
`endif

// file: testbench/pmc_ctrl_sva.sv
// port assertions for the power mode controller
`include "pmc_map.vh"
module pmc_ctrl_sva (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_low,
    input wire logic i_reset_pin,
    input wire logic i_int_reset,
    input wire logic i_irq_pending,
    input wire logic [`PMC_MODE_W-1:0] o_mode,
    input wire logic o_cpu_run,
    input wire logic o_irq_service,
    input wire logic o_idle_bit,
    input wire logic o_core_rst,
    input wire logic o_precision_osc_en,
    input wire logic o_core_reg_en,
    input wire logic o_ram_on_vdd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    chk_supply_rst: assert property (i_supply_low |=> o_core_rst)
        else $error("core reset not held on low supply");
    chk_idle_halt: assert property (o_mode == `PMC_MODE_IDLE |-> !o_cpu_run)
        else $error("cpu runs in idle");
    chk_idle_wake: assert property ((o_mode == `PMC_MODE_IDLE &&
        i_irq_pending) |-> ##[1:2] o_cpu_run) else $error("slow idle wake");
    chk_svc_pulse: assert property (o_irq_service |->
        !o_idle_bit ##1 !o_irq_service) else $error("bad service pulse");
    chk_stop_hold: assert property ((o_mode == `PMC_MODE_STOP &&
        !o_core_rst && !i_reset_pin && !i_int_reset && !i_supply_low)
        |=> o_mode == `PMC_MODE_STOP) else $error("stop left without reset");
    chk_stop_osc: assert property ((o_mode == `PMC_MODE_STOP &&
        $past(o_mode) == `PMC_MODE_STOP) |-> !$past(o_precision_osc_en)
        && !o_cpu_run) else $error("oscillator or cpu on in stop");
    chk_sleep_pwr: assert property ((o_mode == `PMC_MODE_SLEEP &&
        $past(o_mode) == `PMC_MODE_SLEEP) |-> !$past(o_core_reg_en)
        && $past(o_ram_on_vdd)) else $error("core power on in sleep");
    chk_lp_wake: assert property ((o_mode == `PMC_MODE_LP_IDLE &&
        i_irq_pending) |-> ##[1:2] o_mode == `PMC_MODE_LP_ACTIVE)
        else $error("lp idle wake not to lp active");
    cover property (o_irq_service);
    cover property (o_mode == `PMC_MODE_STOP);
    cover property (o_mode == `PMC_MODE_SLEEP);
endmodule // pmc_ctrl_sva

// file: testbench/pmc_fw_model.sv
// firmware model issuing power mode writes
module pmc_fw_model (
    input wire logic i_clk,
    output logic o_idle,
    output logic o_stop,
    output logic o_susp,
    output logic o_sleep,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {o_idle, o_stop, o_susp, o_sleep, o_done} = 5'h00;
    task wr(input logic [3:0] w);
        @(negedge i_clk);
        {o_sleep, o_susp, o_stop, o_idle} = w;
        o_done = |w[3:2];
        if (!o_done) begin
            @(negedge i_clk);
            {o_stop, o_idle} = 2'h0;
            o_done = 1'b1;
        end
        @(negedge i_clk);
        {o_idle, o_stop, o_susp, o_sleep, o_done} = 5'h00;
    endtask
endmodule // pmc_fw_model

// file: testbench/testbench.sv
// self-checking testbench for the power mode controller
`include "pmc_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_sys_rst, i_supply_low, i_reset_pin, i_int_reset;
    logic i_idle_set, i_stop_set, i_suspend_set, i_sleep_set, i_instr_done;
    logic i_lp_mode_set, i_lp_mode_clear, i_irq_pending, i_wake_cap_sense;
    logic i_wake_rtc, i_wake_port_match, i_wake_i2c, o_core_rst;
    logic [7:0] i_periph_clk_en, i_periph_clk_req, i_periph_analog_off;
    logic [7:0] o_periph_clk;
    logic [2:0] o_mode;
    logic [15:0] o_reset_vector;
    logic o_idle_bit, o_stop_bit, o_cpu_run, o_irq_service, o_sysclk_en;
    logic o_precision_osc_en, o_lp_osc_en, o_ext_osc_en, o_rtc_osc_en;
    logic o_core_reg_en, o_ram_on_vdd;
    int errors = 0;
    int checks = 0;
    pmc_power_mode_ctrl DUT (.*);
    pmc_fw_model fw (.i_clk(i_clk), .o_idle(i_idle_set), .o_stop(i_stop_set),
        .o_susp(i_suspend_set), .o_sleep(i_sleep_set), .o_done(i_instr_done));
    task cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wait_run;
        for (int k = 0; k < 20 && o_cpu_run !== 1'b1; k++) cyc(1);
        if (o_cpu_run !== 1'b1) begin
            errors++;
            $display("Error %0t: cpu never resumed", $time);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task t_rst;
        i_supply_low = 1;
        cyc(2);
        chk(o_core_rst, 1'b1);
        i_supply_low = 0;
        cyc(3);
        chk(o_core_rst, 1'b1);
        cyc(4);
        chk(o_core_rst, 1'b0);
    endtask
    task t_idle(input logic lp);
        fw.wr(4'h1);
        cyc(2);
        chk(o_mode, lp ? `PMC_MODE_LP_IDLE : `PMC_MODE_IDLE);
        chk(o_cpu_run, 1'b0);
        chk(o_idle_bit, 1'b1);
        chk(o_periph_clk, lp ? 8'h0c : 8'hff);
        i_irq_pending = 1;
        cyc(1);
        chk(o_irq_service, 1'b1);
        chk(o_idle_bit, 1'b0);
        i_irq_pending = 0;
        cyc(1);
        chk(o_irq_service, 1'b0);
        chk(o_cpu_run, 1'b1);
        chk(o_mode, lp ? `PMC_MODE_LP_ACTIVE : `PMC_MODE_ACTIVE);
        chk(o_periph_clk, lp ? 8'h0c : 8'hff);
    endtask
    task t_idle_rst;
        fw.wr(4'h1);
        cyc(2);
        chk(o_mode, `PMC_MODE_IDLE);
        i_int_reset = 1;
        cyc(1);
        i_int_reset = 0;
        wait_run;
        chk(o_mode, `PMC_MODE_ACTIVE);
        chk(o_idle_bit, 1'b0);
        chk(o_reset_vector, 16'h0000);
    endtask
    task t_stop(input logic [7:0] a);
        logic [2:0] osc;
        osc = (a == 8'h00) ? 3'h3 : 3'h2;
        i_periph_analog_off = a;
        fw.wr(4'h3);
        cyc(2);
        chk(o_mode, `PMC_MODE_STOP);
        chk(o_idle_bit, 1'b0);
        chk(o_stop_bit, 1'b1);
        chk({o_precision_osc_en, o_lp_osc_en, o_ext_osc_en}, osc);
        i_irq_pending = 1;
        cyc(4);
        chk(o_mode, `PMC_MODE_STOP);
        i_irq_pending = 0;
        i_reset_pin = 1;
        cyc(1);
        i_reset_pin = 0;
        wait_run;
        chk(o_mode, `PMC_MODE_ACTIVE);
        chk(o_reset_vector, 16'h0000);
        chk(o_stop_bit, 1'b0);
        i_periph_analog_off = 8'h00;
    endtask
    task t_low(input logic [3:0] w, input logic [2:0] m, input logic [3:0] s);
        fw.wr(w);
        cyc(2);
        chk(o_mode, m);
        chk({o_precision_osc_en, o_lp_osc_en, o_ext_osc_en}, 3'h0);
        if (w[3]) begin
            chk({o_core_reg_en, o_ram_on_vdd, o_rtc_osc_en}, 3'h3);
            i_wake_cap_sense = 1;
            cyc(2);
            i_wake_cap_sense = 0;
            chk(o_mode, m);
        end else begin
            chk(o_sysclk_en, 1'b0);
        end
        {i_wake_i2c, i_wake_port_match, i_wake_rtc, i_wake_cap_sense} = s;
        cyc(1);
        {i_wake_i2c, i_wake_port_match, i_wake_rtc, i_wake_cap_sense} = 4'h0;
        wait_run;
        chk(o_mode, `PMC_MODE_ACTIVE);
    endtask
    initial begin
        i_clk = 0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        {i_supply_low, i_reset_pin, i_int_reset, i_lp_mode_set} = 4'h0;
        {i_lp_mode_clear, i_irq_pending, i_wake_cap_sense} = 3'h0;
        {i_wake_rtc, i_wake_port_match, i_wake_i2c} = 3'h0;
        {i_periph_clk_en, i_periph_clk_req} = 16'h3c0f;
        i_periph_analog_off = 8'h00;
        i_sys_rst = 1;
        cyc(2);
        i_sys_rst = 0;
        cyc(8);
        t_rst;
        t_idle(1'b0);
        t_stop(8'h00);
        t_stop(8'h10);
        t_idle_rst;
        i_lp_mode_set = 1;
        cyc(1);
        i_lp_mode_set = 0;
        t_idle(1'b1);
        i_lp_mode_clear = 1;
        cyc(1);
        i_lp_mode_clear = 0;
        for (int s = 0; s < 4; s++) t_low(4'h4, `PMC_MODE_SUSPEND, 4'h1 << s);
        for (int s = 1; s < 4; s++) t_low(4'h8, `PMC_MODE_SLEEP, 4'h1 << s);
        print_verdict;
    end
    initial begin
        #40000;
        errors++;
        print_verdict;
    end
endmodule // testbench
bind pmc_power_mode_ctrl pmc_ctrl_sva u_sva (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_supply_low(i_supply_low),
    .i_reset_pin(i_reset_pin),
    .i_int_reset(i_int_reset),
    .i_irq_pending(i_irq_pending),
    .o_mode(o_mode),
    .o_cpu_run(o_cpu_run),
    .o_irq_service(o_irq_service),
    .o_idle_bit(o_idle_bit),
    .o_core_rst(o_core_rst),
    .o_precision_osc_en(o_precision_osc_en),
    .o_core_reg_en(o_core_reg_en),
    .o_ram_on_vdd(o_ram_on_vdd)
);
